// ==== verilog/dac_feature_pkg.sv ====
`default_nettype none
package dac_feature_pkg;
    localparam int NUM_CH = 6;

    // Register map, at the printed offsets
    localparam logic [7:0] ADDR_SELECT = 8'h10;
    localparam logic [7:0] ADDR_FEATURES = 8'h11;
    localparam logic [7:0] ADDR_DAC_BASE = 8'h12;
    localparam logic [7:0] ADDR_MIX_BASE = 8'h18;
    localparam logic [15:0] SELECT_RESET = 16'h0000;
    localparam logic [15:0] FEATURES_RESET = 16'h0000;
    localparam logic [15:0] CHANNEL_RESET = 16'h0000;

    // Feature group codes
    localparam logic [1:0] GRP_ALL = 2'h0;
    localparam logic [1:0] GRP_VOLUME = 2'h1;
    localparam logic [1:0] GRP_MUTE = 2'h2;
    localparam logic [1:0] GRP_TONE = 2'h3;
    localparam logic [15:0] GRP_ALL_MASK = 16'hffff;
    localparam logic [15:0] GRP_VOLUME_MASK = 16'h00ff;
    localparam logic [15:0] GRP_MUTE_MASK = 16'h0300;
    localparam logic [15:0] GRP_TONE_MASK = 16'hfc00;

    // Fields each kind of target holds
    localparam logic [15:0] DAC_ODD_MASK = 16'hffff;
    localparam logic [15:0] DAC_EVEN_MASK = 16'h3fff;
    localparam logic [15:0] MIX_ODD_MASK = 16'hc7ff;
    localparam logic [15:0] MIX_EVEN_MASK = 16'h07ff;
    localparam int MUTE_BIT = 9;

    // Mixer source codes
    localparam logic [1:0] MIX_CODE_ADC1 = 2'h2;
    localparam logic [1:0] MIX_CODE_ADC2 = 2'h3;

    // Attenuation code map, in quarter dB
    localparam logic [7:0] ATTEN_FINE_LAST = 8'hd4;
    localparam logic [7:0] ATTEN_MUTE_FIRST = 8'hfc;
    localparam logic [8:0] ATTEN_FINE_END_Q = 9'h0d4;
    localparam logic [8:0] ATTEN_COARSE_STEP_Q = 9'h00c;

    typedef enum logic [1:0] {MIX_NONE, MIX_ADC1, MIX_ADC2} mix_source_e;

    typedef struct packed {
        logic [1:0] mixer_source;
        logic [5:0] blend_channel_enable;
        logic [1:0] feature_group;
        logic [5:0] dac_channel_enable;
    } select_s;

    typedef struct packed {
        logic [1:0] input_pairing_select;
        logic [2:0] emphasis_filter_select;
        logic polarity_invert;
        logic mute_request;
        logic fast_mute_mode;
        logic [7:0] attenuation_code;
    } chan_cfg_s;

    typedef struct packed {
        logic invert;
        logic muted;
        logic fast_mute;
        logic full_mute;
        logic [8:0] atten_q;
    } chan_ctrl_s;
endpackage
`default_nettype wire

// ==== verilog/dac_channel_stage.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_channel_stage
    import dac_feature_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Settings in
    input wire chan_cfg_s cfg_i,
    input wire logic startup_hold_i,
    // Decoded control out
    output chan_ctrl_s ctrl_o
);
    chan_ctrl_s ctrl;
    chan_ctrl_s next_ctrl;
    logic [7:0] coarse_steps;

    always_comb
    begin
        coarse_steps = 8'(cfg_i.attenuation_code - ATTEN_FINE_LAST) >> 2;
        next_ctrl.invert = cfg_i.polarity_invert;
        // Held muted from start-up until software releases it
        next_ctrl.muted = cfg_i.mute_request | startup_hold_i;
        next_ctrl.fast_mute = cfg_i.fast_mute_mode;
        next_ctrl.full_mute = cfg_i.attenuation_code >= ATTEN_MUTE_FIRST;
        if (cfg_i.attenuation_code <= ATTEN_FINE_LAST)
        begin
            next_ctrl.atten_q = {1'b0, cfg_i.attenuation_code};
        end
        else
        begin
            // Codes between two coarse steps round to the lower step
            next_ctrl.atten_q = ATTEN_FINE_END_Q
                + 9'(coarse_steps[3:0] * ATTEN_COARSE_STEP_Q);
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl <= '{invert: 1'b0, muted: 1'b1, fast_mute: 1'b0, full_mute: 1'b0,
                      atten_q: 9'h000};
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    assign ctrl_o = ctrl;

    a_atten_floor: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cfg_i.attenuation_code >= ATTEN_MUTE_FIRST |=> ctrl_o.full_mute)
        else $error("top attenuation codes must give full mute");
    a_atten_minus80: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        cfg_i.attenuation_code == 8'hf8 |=> ctrl_o.atten_q == 9'h140)
        else $error("code f8 must give 80 dB");
    a_fast_mute_follow: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ctrl_o.fast_mute == $past(cfg_i.fast_mute_mode))
        else $error("fast mute mode not forwarded");
endmodule
`default_nettype wire

// ==== verilog/dac_feature_broadcast_regs.sv ====
// Notes on behaviour
// - Select bits 15:14 pick mixer source: 00/01 none, 10 ADC 1, 11 ADC 2.
// - Select bits 13:8 enable which mixing channel registers take feature writes.
// - Select bits 5:0 enable which DAC channel registers take feature writes.
// - Enable bit n-1 picks channel n; zero after reset, none ready.
// - Select bits 7:6 pick the feature group; other fields keep their values.
// - Group 00 all, 01 attenuation, 10 mute pair, 11 emphasis, polarity, pairing.
// - Features register: 16-bit read/write, reset zero, fields as laid out.
// - Polarity bit one inverts the channel output, zero passes it straight.
// - Outputs muted from start-up; mute bit engages and releases muting.
// - Fast mute bit selects quick mute, else soft mute ramping.
// - Attenuation: quarter dB to -53, 3 dB steps to -80, then full mute.
// - Odd DAC channel registers 12h/14h/16h take every field.
// - Even DAC channel registers 13h/15h/17h take all but pairing.
// - Odd mixing registers 18h/1Ah/1Ch take all but emphasis.
// - Even mixing registers 19h/1Bh/1Dh take polarity, mute, fast mute, attenuation.
`timescale 1ns/1ps
`default_nettype none
module dac_feature_broadcast_regs
    import dac_feature_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Mixer and channel settings
    output mix_source_e mix_source_o,
    output chan_cfg_s [NUM_CH-1:0] dac_cfg_o,
    output chan_cfg_s [NUM_CH-1:0] mix_cfg_o,
    output chan_ctrl_s [NUM_CH-1:0] dac_ctrl_o,
    output chan_ctrl_s [NUM_CH-1:0] mix_ctrl_o
);
    select_s sel;
    select_s next_sel;
    logic [15:0] features;
    logic [15:0] next_features;
    mix_source_e mix_source;
    mix_source_e next_mix_source;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [15:0] group_mask;
    logic feat_wr;
    chan_cfg_s [NUM_CH-1:0] dac_cfg;
    chan_cfg_s [NUM_CH-1:0] mix_cfg;
    logic [NUM_CH-1:0] dac_hold;
    logic [NUM_CH-1:0] mix_hold;

    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    assign feat_wr = reg_wr_i && (reg_addr_i == ADDR_FEATURES);

    always_comb
    begin
        case (sel.feature_group)
            GRP_ALL: group_mask = GRP_ALL_MASK;
            GRP_VOLUME: group_mask = GRP_VOLUME_MASK;
            GRP_MUTE: group_mask = GRP_MUTE_MASK;
            GRP_TONE: group_mask = GRP_TONE_MASK;
            default: group_mask = GRP_ALL_MASK;
        endcase
    end

    // Select, features, mixer source and read data
    always_comb
    begin
        next_sel = sel;
        next_features = features;
        next_rdata = rdata;
        next_rvalid = reg_rd_i;
        if (reg_wr_i && (reg_addr_i == ADDR_SELECT))
        begin
            next_sel = reg_wdata_i;
        end
        if (feat_wr)
        begin
            next_features = reg_wdata_i;
        end
        case (sel.mixer_source)
            MIX_CODE_ADC1: next_mix_source = MIX_ADC1;
            MIX_CODE_ADC2: next_mix_source = MIX_ADC2;
            default: next_mix_source = MIX_NONE;
        endcase
        if (reg_rd_i)
        begin
            // Unmapped addresses read as zero
            next_rdata = 16'h0000;
            if (reg_addr_i == ADDR_SELECT)
            begin
                next_rdata = sel;
            end
            if (reg_addr_i == ADDR_FEATURES)
            begin
                next_rdata = features;
            end
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (reg_addr_i == ADDR_DAC_BASE + 8'(i))
                begin
                    next_rdata = dac_cfg[i];
                end
                if (reg_addr_i == ADDR_MIX_BASE + 8'(i))
                begin
                    next_rdata = mix_cfg[i];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sel <= SELECT_RESET;
            features <= FEATURES_RESET;
            mix_source <= MIX_NONE;
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end
        else
        begin
            sel <= next_sel;
            features <= next_features;
            mix_source <= next_mix_source;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_chan
            // Index 0 is channel 1, so even indices are the odd channels
            localparam logic [15:0] DAC_MASK = (g % 2 == 0) ? DAC_ODD_MASK : DAC_EVEN_MASK;
            localparam logic [15:0] MIX_MASK = (g % 2 == 0) ? MIX_ODD_MASK : MIX_EVEN_MASK;
            logic dac_direct;
            logic mix_direct;
            logic dac_bcast;
            logic mix_bcast;
            logic [15:0] dac_upd;
            logic [15:0] mix_upd;
            chan_cfg_s next_dac;
            chan_cfg_s next_mix;
            logic next_dac_hold;
            logic next_mix_hold;

            always_comb
            begin
                dac_direct = reg_wr_i && (reg_addr_i == ADDR_DAC_BASE + 8'(g));
                mix_direct = reg_wr_i && (reg_addr_i == ADDR_MIX_BASE + 8'(g));
                dac_bcast = feat_wr && sel.dac_channel_enable[g];
                mix_bcast = feat_wr && sel.blend_channel_enable[g];
                // Broadcast touches only the chosen group of fields the target holds
                dac_upd = dac_direct ? DAC_MASK
                        : (dac_bcast ? (group_mask & DAC_MASK) : 16'h0000);
                mix_upd = mix_direct ? MIX_MASK
                        : (mix_bcast ? (group_mask & MIX_MASK) : 16'h0000);
                next_dac = merge(dac_cfg[g], reg_wdata_i, dac_upd);
                next_mix = merge(mix_cfg[g], reg_wdata_i, mix_upd);
                // Start-up mute ends only on an explicit mute-bit clear
                next_dac_hold = dac_hold[g] && !(dac_upd[MUTE_BIT]
                                                 && !reg_wdata_i[MUTE_BIT]);
                next_mix_hold = mix_hold[g] && !(mix_upd[MUTE_BIT]
                                                 && !reg_wdata_i[MUTE_BIT]);
            end

            always_ff @(posedge clk_sys_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    dac_cfg[g] <= CHANNEL_RESET;
                    mix_cfg[g] <= CHANNEL_RESET;
                    dac_hold[g] <= 1'b1;
                    mix_hold[g] <= 1'b1;
                end
                else
                begin
                    dac_cfg[g] <= next_dac;
                    mix_cfg[g] <= next_mix;
                    dac_hold[g] <= next_dac_hold;
                    mix_hold[g] <= next_mix_hold;
                end
            end

            dac_channel_stage u_dac_stage (
                .clk_sys_i(clk_sys_i),
                .resetn_i(resetn_i),
                .cfg_i(dac_cfg[g]),
                .startup_hold_i(dac_hold[g]),
                .ctrl_o(dac_ctrl_o[g])
            );

            dac_channel_stage u_mix_stage (
                .clk_sys_i(clk_sys_i),
                .resetn_i(resetn_i),
                .cfg_i(mix_cfg[g]),
                .startup_hold_i(mix_hold[g]),
                .ctrl_o(mix_ctrl_o[g])
            );
        end
    endgenerate

    assign reg_rdata_o = rdata;
    assign reg_rvalid_o = rvalid;
    assign mix_source_o = mix_source;
    assign dac_cfg_o = dac_cfg;
    assign mix_cfg_o = mix_cfg;

    sequence s_feat_wr_ch1;
        reg_wr_i && reg_addr_i == ADDR_FEATURES && sel.dac_channel_enable[0];
    endsequence

    sequence s_feat_wr_off1;
        reg_wr_i && reg_addr_i == ADDR_FEATURES && !sel.dac_channel_enable[0];
    endsequence

    sequence s_feat_readback;
        (reg_wr_i && reg_addr_i == ADDR_FEATURES)
        ##1 !reg_wr_i
        ##1 (reg_rd_i && !reg_wr_i && reg_addr_i == ADDR_FEATURES);
    endsequence

    a_fanout_all_dac: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_feat_wr_ch1 and (sel.feature_group == GRP_ALL)
        |=> dac_cfg_o[0] == $past(reg_wdata_i))
        else $error("enabled DAC channel 1 missed the feature write");
    a_disabled_dac_kept: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_feat_wr_off1 |=> $stable(dac_cfg_o[0]))
        else $error("disabled DAC channel 1 changed");
    a_mix_enable_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        feat_wr && !sel.blend_channel_enable[2] |=> $stable(mix_cfg_o[2]))
        else $error("disabled mixing channel 3 changed");
    a_volume_group_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_feat_wr_ch1 and (sel.feature_group == GRP_VOLUME)
        |=> dac_cfg_o[0][15:8] == $past(dac_cfg_o[0][15:8])
            && dac_cfg_o[0].attenuation_code == $past(reg_wdata_i[7:0]))
        else $error("volume group write touched other fields");
    a_even_dac_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        dac_cfg_o[1].input_pairing_select == 2'h0)
        else $error("even DAC channel holds pairing");
    a_mix_odd_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mix_cfg_o[0].emphasis_filter_select == 3'h0)
        else $error("odd mixing channel holds emphasis");
    a_mix_even_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mix_cfg_o[1][15:11] == 5'h00)
        else $error("even mixing channel holds pairing or emphasis");
    a_feat_readback: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_feat_readback |=> reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("features read did not return last write");
    a_startup_muted: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        dac_hold[0] |=> dac_ctrl_o[0].muted)
        else $error("channel 1 unmuted before release");
    a_mix_source_map: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sel.mixer_source == MIX_CODE_ADC2 ##1 sel.mixer_source == MIX_CODE_ADC2
        |-> mix_source_o == MIX_ADC2)
        else $error("mixer source decode wrong");
    a_invert_follow: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        dac_cfg_o[3].polarity_invert |=> dac_ctrl_o[3].invert)
        else $error("polarity not applied");
    a_read_answer: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reg_rd_i |=> reg_rvalid_o)
        else $error("read strobe got no answer");
    a_select_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == ADDR_SELECT |=> sel == $past(reg_wdata_i))
        else $error("select register write lost");
    a_feature_store: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        feat_wr |=> features == $past(reg_wdata_i))
        else $error("features register write lost");
    a_mix_source_adc1: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        sel.mixer_source == MIX_CODE_ADC1 |=> mix_source_o == MIX_ADC1)
        else $error("mixer source ADC 1 decode wrong");
    a_mute_group_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_feat_wr_ch1 and (sel.feature_group == GRP_MUTE)
        |=> dac_cfg_o[0][9:8] == $past(reg_wdata_i[9:8])
            && dac_cfg_o[0][15:10] == $past(dac_cfg_o[0][15:10])
            && dac_cfg_o[0][7:0] == $past(dac_cfg_o[0][7:0]))
        else $error("mute group write touched other fields");
    a_tone_group_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        s_feat_wr_ch1 and (sel.feature_group == GRP_TONE)
        |=> dac_cfg_o[0][15:10] == $past(reg_wdata_i[15:10])
            && dac_cfg_o[0][9:0] == $past(dac_cfg_o[0][9:0]))
        else $error("tone group write touched other fields");
    a_even_dac_copy: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        feat_wr && sel.dac_channel_enable[1] && sel.feature_group == GRP_ALL
        |=> dac_cfg_o[1] == ($past(reg_wdata_i) & DAC_EVEN_MASK))
        else $error("even DAC channel 2 copy wrong");
    a_odd_mix_copy: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        feat_wr && sel.blend_channel_enable[0] && sel.feature_group == GRP_ALL
        |=> mix_cfg_o[0] == ($past(reg_wdata_i) & MIX_ODD_MASK))
        else $error("odd mixing channel 1 copy wrong");
    a_even_mix_copy: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        feat_wr && sel.blend_channel_enable[1] && sel.feature_group == GRP_ALL
        |=> mix_cfg_o[1] == ($past(reg_wdata_i) & MIX_EVEN_MASK))
        else $error("even mixing channel 2 copy wrong");
endmodule
`default_nettype wire

// ==== bench/dac_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Register port towards the device
    output logic [7:0] reg_addr_o,
    output logic [15:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial
    begin
        reg_addr_o = 8'h00;
        reg_wdata_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // Released lines carry the inverse so a stale value cannot pass
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(posedge clk_sys_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1;
        ok = reg_rvalid_i;
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== bench/dac_feature_broadcast_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dac_feature_broadcast_regs_tb
    import dac_feature_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    mix_source_e mix_src;
    chan_cfg_s [NUM_CH-1:0] dac_cfg;
    chan_cfg_s [NUM_CH-1:0] mix_cfg;
    chan_ctrl_s [NUM_CH-1:0] dac_ctrl;
    chan_ctrl_s [NUM_CH-1:0] mix_ctrl;
    int failures = 0;
    int n_compared = 0;
    int sel = 0;
    int feat = 0;
    int cfg[2][NUM_CH];
    int hold[2][NUM_CH];
    logic [31:0] seed = 32'hd506;
    int codes[8] = '{'h00, 'h01, 'hd4, 'hd8, 'hf8, 'hfb, 'hfc, 'hff};
    logic [15:0] rd_data;
    logic rd_ok;

    always #50 clk_sys_i = ~clk_sys_i;

    dac_host_model u_host (
        .clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata),
        .reg_rvalid_i(reg_rvalid)
    );

    dac_feature_broadcast_regs u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .mix_source_o(mix_src),
        .dac_cfg_o(dac_cfg), .mix_cfg_o(mix_cfg), .dac_ctrl_o(dac_ctrl),
        .mix_ctrl_o(mix_ctrl)
    );

    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic int tmask(int k, int i);
        if (k == 1)
            return (i % 2 == 0) ? 'hc7ff : 'h07ff;
        return (i % 2 == 0) ? 'hffff : 'h3fff;
    endfunction

    function automatic int gmask(int g);
        case (g)
            0: return 'hffff;
            1: return 'h00ff;
            2: return 'h0300;
            default: return 'hfc00;
        endcase
    endfunction

    task automatic upd(input int k, input int i, input int d, input int m);
        int t;
        t = tmask(k, i) & m;
        cfg[k][i] = (cfg[k][i] & ~t) | (d & t);
        if (t[9] && !d[9])
            hold[k][i] = 0;
    endtask

    task automatic check_all();
        logic [12:0] seen;
        logic [12:0] e;
        int c;
        int q;
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(mix_src, (sel[15:14] == 2) ? 2'(MIX_ADC1)
            : (sel[15:14] == 3) ? 2'(MIX_ADC2) : 2'(MIX_NONE), "mixer");
        for (int k = 0; k < 2; k++)
            for (int i = 0; i < NUM_CH; i++)
            begin
                c = cfg[k][i];
                chk(k ? mix_cfg[i] : dac_cfg[i], c,
                    "channel");
                seen = k ? mix_ctrl[i] : dac_ctrl[i];
                q = (c[7:0] <= 'hd4) ? c[7:0] : 'hd4 + 12 * ((c[7:0] - 'hd4) / 4);
                e = {c[10], 1'(hold[k][i]) | c[9], c[8], c[7:0] >= 'hfc, 9'(q)};
                // Step value is a don't-care once the code mutes fully
                if (c[7:0] >= 'hfc)
                begin
                    seen[8:0] = 9'h0;
                    e[8:0] = 9'h0;
                end
                chk(seen, e, "control");
            end
    endtask

    task automatic mwr(input int a, input int d);
        u_host.wr(a[7:0], d[15:0]);
        if (a == 'h10)
            sel = d;
        else if (a == 'h11)
        begin
            feat = d;
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (sel[i])
                    upd(0, i, d, gmask(sel[7:6]));
                if (sel[8 + i])
                    upd(1, i, d, gmask(sel[7:6]));
            end
        end
        else if (a >= 'h12 && a <= 'h17)
            upd(0, a - 'h12, d, 'hffff);
        else if (a >= 'h18 && a <= 'h1d)
            upd(1, a - 'h18, d, 'hffff);
        check_all();
    endtask

    task automatic rd_all();
        logic [15:0] d;
        logic ok;
        int e;
        for (int a = 'h0e; a <= 'h1f; a++)
        begin
            u_host.rd(a[7:0], d, ok);
            e = (a == 'h10) ? sel : (a == 'h11) ? feat : 0;
            if (a >= 'h12 && a <= 'h17)
                e = cfg[0][a - 'h12];
            if (a >= 'h18 && a <= 'h1d)
                e = cfg[1][a - 'h18];
            chk(ok, 1'b1, "read answer");
            chk(d, e, "read data");
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        failures++;
        close_out();
    end

    initial
    begin
        for (int k = 0; k < 2; k++)
            for (int i = 0; i < NUM_CH; i++)
            begin
                cfg[k][i] = 0;
                hold[k][i] = 1;
            end
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        check_all();
        rd_all();
        for (int m = 0; m < 4; m++)
            mwr('h10, m << 14);
        mwr('h11, 'h4000);
        // Host pairs the odd channels and lifts the start-up mute
        mwr('h10, 'h3f3f);
        mwr('h11, 'h8000);
        for (int n = 0; n < 32; n++)
        begin
            seed = lfsr(seed);
            mwr('h10, (n == 1) ? 0
                : ((seed[15:0] & 'hff3f) | ((n % 4) << 6)));
            seed = lfsr(seed);
            mwr('h11, seed[15:0]);
        end
        mwr('h10, 'h3f7f);
        foreach (codes[j])
            mwr('h11, codes[j] | 'h0500);
        for (int a = 'h0f; a <= 'h1e; a++)
        begin
            seed = lfsr(seed);
            if (a != 'h10 && a != 'h11)
                mwr(a, seed[15:0]);
        end
        // Nothing selected, so this write only lands in the features register
        mwr('h10, 'h0000);
        seed = lfsr(seed);
        feat = seed[15:0];
        u_host.wr(8'h11, seed[15:0]);
        u_host.rd(8'h11, rd_data, rd_ok);
        chk(rd_ok, 1'b1, "features answer");
        chk(rd_data, feat, "features readback");
        rd_all();
        close_out();
    end
endmodule
`default_nettype wire
